// ==== rtl/sscd_pkg.sv ====
// package: constants and carriers for the supervisory call dispatcher
// Functional notes
// (RQ1) Opcode 00h executed by the CPU enters the supervisory routine.
// (RQ2) Accumulator code selects boot, read, write, erase, full erase, table, checksum.
// (RQ3) An undefined function code halts the CPU.
// (RQ4) Caller provides free stack space for each function.
// (RQ5) Caller sets up the parameter block at SRAM F8h to FFh.
// (RQ6) Caller loads first_key with 3Ah before any call.
// (RQ7) Caller loads second_key with stack pointer at the call plus three.
// (RQ8) Both keys are checked; a mismatch halts, except for boot reset.
// (RQ9) Return code in first_key: 00h ok, 01h protected, 02h soft reset, 03h fatal.
// (RQ10) Checksum and table read return data in first_key, not a code.
// (RQ11) Full erase does erase, program zeros, erase on every macro.
// (RQ12) Then a second loop erases and zero-programs each protection block.
// (RQ13) Hardware reset runs boot reset; code 00h does too; no parameter block used.
// (RQ14) A bad key with a nonzero code halts instead of running boot reset.
// (RQ15) Boot reset checks calibration data with a 16-bit checksum before release.
// (RQ16) Block read copies 64 contiguous flash bytes of block_number into SRAM.
// (RQ17) Read protected block: accumulator and second_key 00h, first_key 01h.
// (RQ18) Block read stores bytes from the address held at 0,FBh upward.
// (RQ19) Successful block read leaves accumulator, first_key, second_key at 00h.
// (RQ20) External controller enters serial programming mode and queues flash functions.
// (RQ21) The supervisory ROM lives in a space apart from user program memory.
// (RQ22) After a non-halting function the CPU resumes after the call.
package sscd_pkg;
  localparam logic [7:0] SSC_OPCODE = 8'h00;
  // function codes
  localparam logic [7:0] FN_BOOT = 8'h00;
  localparam logic [7:0] FN_READ = 8'h01;
  localparam logic [7:0] FN_WRITE = 8'h02;
  localparam logic [7:0] FN_ERASE = 8'h03;
  localparam logic [7:0] FN_ERASE_ALL = 8'h05;
  localparam logic [7:0] FN_TABLE = 8'h06;
  localparam logic [7:0] FN_CHECKSUM = 8'h07;
  // parameter block in SRAM bank 0
  localparam logic [7:0] PB_FIRST_KEY = 8'hF8;
  localparam logic [7:0] PB_SECOND_KEY = 8'hF9;
  localparam logic [7:0] FIRST_KEY_VALUE = 8'h3A;
  localparam logic [7:0] SECOND_KEY_SP_OFFSET = 8'h03;
  // return codes
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_PROT = 8'h01;
  localparam logic [7:0] RC_SWRST = 8'h02;
  localparam logic [7:0] RC_FATAL = 8'h03;
  // flash geometry and auxiliary rows
  localparam int FLASH_AW = 13;
  localparam logic [5:0] BLOCK_LAST = 6'h3F;
  localparam logic [5:0] CAL_LAST = 6'h3F;
  localparam logic [5:0] TABLE_LAST = 6'h00;
  localparam logic [12:0] PROT_BASE = 13'h0000;
  localparam logic [12:0] CAL_BASE = 13'h0040;
  localparam logic [12:0] TABLE_BASE = 13'h0080;
  localparam logic [1:0] NUM_MACROS_M1 = 2'h0;
  // protection levels
  localparam logic [1:0] PROT_READ = 2'h1;
  localparam logic [1:0] PROT_EXT_WR = 2'h2;
  localparam logic [1:0] PROT_INT_WR = 2'h3;
  // apb register map
  localparam logic [11:0] REG_QUEUE = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CAL_SUM = 12'h008;
  localparam logic [11:0] REG_RESULT = 12'h00C;
  localparam logic [15:0] CAL_SUM_RESET = 16'h0000;

  typedef enum logic [2:0] {
    FOP_NONE = 3'b000,
    FOP_ERASE = 3'b001,
    FOP_PROG_ZERO = 3'b010,
    FOP_PROT_ERASE = 3'b011,
    FOP_PROT_ZERO = 3'b100,
    FOP_ROW_ERASE = 3'b101,
    FOP_ROW_WRITE = 3'b110
  } sscd_fop_e;

  typedef struct packed {
    sscd_fop_e op;
    logic [1:0] macro;
    logic [6:0] block;
    logic [7:0] ptr;
  } sscd_fop_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } sscd_sram_s;
endpackage

// ==== rtl/sscd_sync2.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sscd_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sscd_sync2

// ==== rtl/sscd_dispatcher.sv ====
// supervisory call dispatcher: call decode, key check and flash sequences
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module sscd_dispatcher (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu core
  input wire logic cpu_exec,
  input wire logic [7:0] cpu_opcode,
  input wire logic [7:0] cpu_acc,
  input wire logic [7:0] cpu_sp,
  output logic cpu_hold,
  output logic cpu_halt,
  output logic cpu_resume,
  output logic acc_clear,
  output logic supervisory_rom_space,
  // sram port, read data valid in the same cycle as re
  output sscd_pkg::sscd_sram_s sram,
  input wire logic [7:0] sram_rdata,
  // flash read port, data valid in the same cycle as re
  output logic [12:0] flash_addr,
  output logic flash_aux,
  output logic flash_re,
  input wire logic [7:0] flash_rdata,
  // flash operation sequencer
  output sscd_pkg::sscd_fop_s fop,
  output logic fop_req,
  input wire logic fop_done,
  // serial programming pins
  input wire logic serial_prog_pin_a,
  input wire logic serial_prog_pin_b
);
  import sscd_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SUM_RD = 4'b0001,
    ST_SUM_ACC = 4'b0010,
    ST_PRM_RD = 4'b0011,
    ST_PRM_CAP = 4'b0100,
    ST_DISPATCH = 4'b0101,
    ST_PROT_RD = 4'b0110,
    ST_PROT_CHK = 4'b0111,
    ST_COPY_RD = 4'b1000,
    ST_COPY_WR = 4'b1001,
    ST_FOP = 4'b1010,
    ST_RET = 4'b1011,
    ST_HALT = 4'b1100
  } sscd_state_e;

  sscd_state_e state;
  logic [1:0] pins_s;
  logic prog_mode;
  logic boot_pend;
  logic hw_boot;
  logic ext;
  logic [7:0] fn;
  logic [7:0] call_sp;
  logic [7:0] prm [4];
  logic [1:0] pidx;
  logic [5:0] cnt;
  logic [5:0] sum_last;
  logic [12:0] sum_base;
  logic sum_aux;
  logic [15:0] sum;
  logic [15:0] next_sum;
  logic [2:0] step;
  logic [1:0] macro;
  logic [7:0] ret_first_key;
  logic ret_k1_en;
  logic ret_k2_en;
  logic ret_halt;
  logic ret_step;
  logic [15:0] cal_sum;
  logic [7:0] last_result;
  logic cpu_call;
  logic wr_queue;
  logic [7:0] start_code;
  logic keys_ok;
  logic [1:0] prot_lvl;
  logic forbid;
  logic [12:0] blk_addr;
  logic apb_wr;

  //////////////////////////////////////////////////////////////////////
  // pins and decode

  sscd_sync2 #(.W(2)) i_sscd_sync2 (
    .pclk(pclk),
    .presetn(presetn),
    .d({serial_prog_pin_a, serial_prog_pin_b}),
    .q(pins_s)
  );

  // (RQ20) programming mode entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_mode <= 1'b0;
    end else begin
      prog_mode <= pins_s[1] & ~pins_s[0];
    end
  end

  // (RQ1) supervisory opcode decode
  assign cpu_call = cpu_exec && (cpu_opcode == SSC_OPCODE) && (state == ST_IDLE);
  assign apb_wr = psel && penable && pwrite;
  // (RQ20) test queue entry
  assign wr_queue = apb_wr && (paddr == REG_QUEUE) && prog_mode && (state == ST_IDLE);
  assign start_code = cpu_call ? cpu_acc : pwdata[7:0];
  // (RQ8) both keys compared
  assign keys_ok = (prm[0] == FIRST_KEY_VALUE) && (prm[1] == 8'(call_sp + SECOND_KEY_SP_OFFSET));
  assign next_sum = sum + {8'h00, flash_rdata};
  assign blk_addr = {prm[2][6:0], 6'h00};
  assign prot_lvl = 2'(flash_rdata >> {prm[2][1:0], 1'b0});

  // read blocked by read protection; writes by internal or external lockout
  always_comb begin
    if (fn == FN_READ) begin
      forbid = (prot_lvl == PROT_READ) || (prot_lvl == PROT_INT_WR);
    end else if (ext) begin
      forbid = (prot_lvl == PROT_EXT_WR) || (prot_lvl == PROT_INT_WR);
    end else begin
      forbid = (prot_lvl == PROT_INT_WR);
    end
  end

  // (RQ11) full erase step order
  function automatic sscd_fop_e step_op(input logic [2:0] s);
    unique case (s)
      3'd0: step_op = FOP_ERASE;
      3'd1: step_op = FOP_PROG_ZERO;
      3'd2: step_op = FOP_ERASE;
      3'd3: step_op = FOP_PROT_ERASE;
      3'd4: step_op = FOP_PROT_ZERO;
      default: step_op = FOP_NONE;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      // (RQ13) hardware reset runs boot
      boot_pend <= 1'b1;
      hw_boot <= 1'b0;
      ext <= 1'b0;
      fn <= FN_BOOT;
      call_sp <= 8'h00;
      prm <= '{default: 8'h00};
      pidx <= 2'd0;
      cnt <= 6'd0;
      sum_last <= 6'd0;
      sum_base <= 13'h0000;
      sum_aux <= 1'b0;
      sum <= 16'h0000;
      step <= 3'd0;
      macro <= 2'd0;
      ret_first_key <= RC_OK;
      ret_k1_en <= 1'b0;
      ret_k2_en <= 1'b0;
      ret_halt <= 1'b0;
      ret_step <= 1'b0;
      last_result <= 8'h00;
      sram <= '0;
      flash_addr <= 13'h0000;
      flash_aux <= 1'b0;
      flash_re <= 1'b0;
      cpu_resume <= 1'b0;
      acc_clear <= 1'b0;
    end else begin
      sram.we <= 1'b0;
      sram.re <= 1'b0;
      flash_re <= 1'b0;
      cpu_resume <= 1'b0;
      acc_clear <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (boot_pend || cpu_call || wr_queue) begin
            boot_pend <= 1'b0;
            hw_boot <= boot_pend;
            ext <= !boot_pend && !cpu_call;
            fn <= boot_pend ? FN_BOOT : start_code;
            call_sp <= cpu_sp;
            cnt <= 6'd0;
            sum <= 16'h0000;
            pidx <= 2'd0;
            // (RQ13) boot ignores the parameter block
            if (boot_pend || start_code == FN_BOOT) begin
              sum_base <= CAL_BASE;
              sum_aux <= 1'b1;
              sum_last <= CAL_LAST;
              state <= ST_SUM_RD;
            end else begin
              state <= ST_PRM_RD;
            end
          end
        end
        ST_SUM_RD: begin
          flash_re <= 1'b1;
          flash_aux <= sum_aux;
          flash_addr <= sum_base + {7'h00, cnt};
          state <= ST_SUM_ACC;
        end
        ST_SUM_ACC: begin
          sum <= next_sum;
          cnt <= cnt + 6'd1;
          state <= ST_SUM_RD;
          if (cnt == sum_last) begin
            state <= ST_RET;
            ret_k2_en <= 1'b0;
            ret_k1_en <= 1'b1;
            ret_halt <= 1'b0;
            if (fn == FN_BOOT) begin
              ret_k1_en <= !hw_boot;
              // (RQ15) calibration checksum gate
              if (next_sum == cal_sum) begin
                ret_first_key <= hw_boot ? RC_OK : RC_SWRST;
              end else begin
                ret_first_key <= RC_FATAL;
                ret_halt <= 1'b1;
              end
            end else begin
              // (RQ10) data instead of code
              ret_first_key <= next_sum[7:0];
            end
          end
        end
        ST_PRM_RD: begin
          sram.re <= 1'b1;
          sram.addr <= PB_FIRST_KEY + {6'h00, pidx};
          state <= ST_PRM_CAP;
        end
        ST_PRM_CAP: begin
          prm[pidx] <= sram_rdata;
          pidx <= pidx + 2'd1;
          state <= (pidx == 2'd3) ? ST_DISPATCH : ST_PRM_RD;
        end
        ST_DISPATCH: begin
          cnt <= 6'd0;
          // (RQ14) bad key with a nonzero code halts
          if (!keys_ok) begin
            state <= ST_HALT;
          end else begin
            // (RQ2) function decode
            unique case (fn)
              FN_READ, FN_WRITE, FN_ERASE: state <= ST_PROT_RD;
              FN_ERASE_ALL: begin
                step <= 3'd0;
                macro <= NUM_MACROS_M1;
                state <= ST_FOP;
              end
              FN_TABLE: begin
                sum_base <= TABLE_BASE + {6'h00, prm[2][6:0]};
                sum_aux <= 1'b1;
                sum_last <= TABLE_LAST;
                state <= ST_SUM_RD;
              end
              FN_CHECKSUM: begin
                sum_base <= blk_addr;
                sum_aux <= 1'b0;
                sum_last <= BLOCK_LAST;
                state <= ST_SUM_RD;
              end
              // (RQ3) undefined code halts
              default: state <= ST_HALT;
            endcase
          end
        end
        ST_PROT_RD: begin
          flash_re <= 1'b1;
          flash_aux <= 1'b1;
          flash_addr <= PROT_BASE + {7'h00, prm[2][7:2]};
          state <= ST_PROT_CHK;
        end
        ST_PROT_CHK: begin
          ret_k1_en <= 1'b1;
          ret_k2_en <= 1'b1;
          ret_halt <= 1'b0;
          ret_first_key <= RC_OK;
          if (forbid) begin
            // (RQ17) protected block exit
            ret_first_key <= RC_PROT;
            state <= ST_RET;
          end else if (fn == FN_READ) begin
            state <= ST_COPY_RD;
          end else begin
            step <= 3'd7;
            state <= ST_FOP;
          end
        end
        ST_COPY_RD: begin
          // (RQ16) 64 contiguous bytes
          flash_re <= 1'b1;
          flash_aux <= 1'b0;
          flash_addr <= blk_addr + {7'h00, cnt};
          state <= ST_COPY_WR;
        end
        ST_COPY_WR: begin
          // (RQ18) destination from pointer
          sram.we <= 1'b1;
          sram.addr <= prm[3] + {2'b00, cnt};
          sram.wdata <= flash_rdata;
          cnt <= cnt + 6'd1;
          state <= (cnt == BLOCK_LAST) ? ST_RET : ST_COPY_RD;
        end
        ST_FOP: begin
          if (fop_done) begin
            ret_first_key <= RC_OK;
            ret_k1_en <= 1'b1;
            ret_k2_en <= 1'b1;
            ret_halt <= 1'b0;
            if (fn != FN_ERASE_ALL) begin
              state <= ST_RET;
            end else if (step == 3'd2) begin
              // (RQ11) next lower macro
              step <= (macro == 2'd0) ? 3'd3 : 3'd0;
              macro <= (macro == 2'd0) ? NUM_MACROS_M1 : macro - 2'd1;
            end else if (step == 3'd4) begin
              // (RQ12) protection loop
              step <= 3'd3;
              macro <= macro - 2'd1;
              if (macro == 2'd0) begin
                state <= ST_RET;
              end
            end else begin
              step <= step + 3'd1;
            end
          end
        end
        ST_RET: begin
          ret_step <= ~ret_step;
          if (!ret_step) begin
            // (RQ9) return code to first key
            sram.we <= ret_k1_en;
            sram.addr <= PB_FIRST_KEY;
            sram.wdata <= ret_first_key;
            last_result <= ret_first_key;
          end else begin
            // (RQ19) second key cleared
            sram.we <= ret_k2_en;
            sram.addr <= PB_SECOND_KEY;
            sram.wdata <= 8'h00;
            if (ret_halt) begin
              state <= ST_HALT;
            end else begin
              // (RQ22) resume after the call
              state <= ST_IDLE;
              cpu_resume <= !ext;
              acc_clear <= !ext && ret_k2_en;
            end
          end
        end
        ST_HALT: state <= ST_HALT;
        default: state <= ST_HALT;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs to cpu and flash

  assign cpu_hold = (state != ST_IDLE) || boot_pend;
  assign cpu_halt = (state == ST_HALT);
  // (RQ21) separate rom space select
  assign supervisory_rom_space = (state != ST_IDLE) && (state != ST_HALT);
  assign fop_req = (state == ST_FOP);

  // row operations carry the block and pointer; sequence steps carry the macro
  always_comb begin
    fop.macro = macro;
    fop.block = prm[2][6:0];
    fop.ptr = prm[3];
    if (fn == FN_ERASE_ALL) begin
      fop.op = step_op(step);
    end else if (fn == FN_WRITE) begin
      fop.op = FOP_ROW_WRITE;
    end else begin
      fop.op = FOP_ROW_ERASE;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // apb registers, zero wait states

  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr != REG_QUEUE) && (paddr != REG_STATUS)
    && (paddr != REG_CAL_SUM) && (paddr != REG_RESULT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_sum <= CAL_SUM_RESET;
    end else if (apb_wr && paddr == REG_CAL_SUM) begin
      cal_sum <= pwdata[15:0];
    end
  end

  // read data sampled in the setup phase, stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        REG_STATUS: prdata <= {16'h0000, fn, 4'h0, prog_mode, cpu_halt, cpu_hold, ext};
        REG_CAL_SUM: prdata <= {16'h0000, cal_sum};
        REG_RESULT: prdata <= {sum, 8'h00, last_result};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // sscd_dispatcher

// ==== sim/sscd_dispatcher_props.sv ====
// checker: port-level properties of the call dispatcher
`timescale 1ns/1ps
module sscd_dispatcher_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // cpu
  input wire logic cpu_exec,
  input wire logic [7:0] cpu_opcode,
  input wire logic cpu_hold,
  input wire logic cpu_halt,
  input wire logic cpu_resume,
  input wire logic acc_clear,
  input wire logic supervisory_rom_space,
  // flash
  input wire logic flash_re,
  input wire sscd_pkg::sscd_fop_s fop,
  input wire logic fop_req,
  input wire logic fop_done
);
  import sscd_pkg::*;
  logic mapped;
  assign mapped = paddr inside {REG_QUEUE, REG_STATUS, REG_CAL_SUM, REG_RESULT};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  // call opcode taken
  chk_call_taken: assert property (
    cpu_exec && cpu_opcode == SSC_OPCODE && !cpu_hold && !cpu_halt |=> cpu_hold)
    else $error("call not taken");
  chk_halt_sticky: assert property (
    cpu_halt |=> cpu_halt) else $error("halt dropped");
  chk_halt_silent: assert property (
    cpu_halt |-> !cpu_resume && !acc_clear) else $error("resume while halted");
  chk_resume_idle: assert property (
    cpu_resume |-> !cpu_hold && !cpu_halt) else $error("resume while busy");
  chk_resume_space: assert property (
    cpu_resume |-> $past(supervisory_rom_space)) else $error("rom space not selected");
  // one flash byte per two cycles
  chk_flash_pace: assert property (
    flash_re |=> !flash_re) else $error("flash read too fast");
  chk_fop_hold: assert property (
    fop_req && !fop_done |=> fop_req && $stable(fop)) else $error("flash op dropped");
  chk_apb_resp: assert property (
    psel && penable |-> pready && pslverr == !mapped) else $error("bad apb response");
endmodule // sscd_dispatcher_props

// ==== sim/sscd_mem_model.sv ====
// partner model: sram, flash with aux rows, flash op sequencer
`timescale 1ns/1ps
module sscd_mem_model (
  // clock
  input wire logic pclk,
  // sram
  input wire sscd_pkg::sscd_sram_s sram,
  output logic [7:0] sram_rdata,
  // flash
  input wire logic [12:0] flash_addr,
  input wire logic flash_aux,
  input wire logic flash_re,
  output logic [7:0] flash_rdata,
  input wire logic fop_req,
  output logic fop_done
);
  import sscd_pkg::*;
  logic [7:0] mem [256];
  logic [7:0] aux [256];
  logic [1:0] cnt;
  logic [7:0] flash_byte;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    foreach (aux[i]) aux[i] = 8'h00;
    // block 2 read protected, calibration all zero
    aux[0] = 8'h10;
    aux[8'h83] = 8'h5C;
    cnt = 2'h0;
    fop_done = 1'b0;
  end
  always @(posedge pclk) begin
    if (sram.we) mem[sram.addr] <= sram.wdata;
  end
  // the dispatcher captures at the edge that ends the strobe cycle, so reads answer at once;
  // idle data is inverted so a stale byte never looks valid
  assign sram_rdata = sram.re ? mem[sram.addr] : ~mem[sram.addr];
  assign flash_byte = flash_aux ? aux[flash_addr[7:0]] : flash_addr[7:0];
  assign flash_rdata = flash_re ? flash_byte : ~flash_byte;
  // each flash op takes a few cycles, never instant
  always @(posedge pclk) begin
    fop_done <= fop_req && cnt == 2'h2;
    cnt <= (fop_req && !fop_done && cnt != 2'h2) ? cnt + 2'h1 : 2'h0;
  end
endmodule // sscd_mem_model

// ==== sim/test_sscd_dispatcher.sv ====
// testbench: calls, flash sequences and apb access of the dispatcher
`timescale 1ns/1ps
module test_sscd_dispatcher;
  import sscd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_a, pin_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cpu_exec, cpu_hold, cpu_halt, cpu_resume, acc_clear, supervisory_rom_space, er;
  logic [7:0] cpu_opcode, cpu_acc, cpu_sp, sram_rdata, flash_rdata, sum;
  logic [12:0] flash_addr;
  logic flash_aux, flash_re, fop_req, fop_done;
  sscd_sram_s sram;
  sscd_fop_s fop;
  sscd_fop_e ops[$];
  sscd_fop_e exp[$];
  int failures, n_tests, n_res, n_clr, n0;
  sscd_dispatcher i_sscd_dispatcher (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_exec(cpu_exec), .cpu_opcode(cpu_opcode),
    .cpu_acc(cpu_acc), .cpu_sp(cpu_sp), .cpu_hold(cpu_hold), .cpu_halt(cpu_halt),
    .cpu_resume(cpu_resume), .acc_clear(acc_clear), .supervisory_rom_space(supervisory_rom_space), .sram(sram),
    .sram_rdata(sram_rdata), .flash_addr(flash_addr), .flash_aux(flash_aux),
    .flash_re(flash_re), .flash_rdata(flash_rdata), .fop(fop), .fop_req(fop_req),
    .fop_done(fop_done), .serial_prog_pin_a(pin_a), .serial_prog_pin_b(pin_b));
  sscd_mem_model i_sscd_mem_model (.pclk(pclk), .sram(sram), .sram_rdata(sram_rdata),
    .flash_addr(flash_addr), .flash_aux(flash_aux), .flash_re(flash_re),
    .flash_rdata(flash_rdata), .fop_req(fop_req), .fop_done(fop_done));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (cpu_resume === 1'b1) n_res++;
    if (acc_clear === 1'b1) n_clr++;
    if (fop_req === 1'b1 && fop_done === 1'b1) ops.push_back(fop.op);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wait_idle();
    do begin
      @(posedge pclk);
    end while (cpu_hold !== 1'b0 && cpu_halt !== 1'b1);
    // the last return write lands at this edge
    @(posedge pclk);
  endtask
  task automatic rst();
    presetn <= 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    wait_idle();
  endtask
  // caller parameter block, stack room left below sp
  task automatic pblk(input logic [7:0] k1, input logic [7:0] sp, input logic [7:0] blk);
    i_sscd_mem_model.mem[PB_FIRST_KEY] = k1;
    i_sscd_mem_model.mem[PB_SECOND_KEY] = sp + SECOND_KEY_SP_OFFSET;
    i_sscd_mem_model.mem[8'hFA] = blk;
    i_sscd_mem_model.mem[8'hFB] = 8'h10;
    cpu_sp <= sp;
  endtask
  task automatic call(input logic [7:0] fn);
    n0 = n_res;
    cpu_exec <= 1;
    cpu_opcode <= SSC_OPCODE;
    cpu_acc <= fn;
    @(posedge pclk);
    cpu_exec <= 0;
    wait_idle();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_read();
    pblk(FIRST_KEY_VALUE, 8'h40, 8'h01);
    call(FN_READ);
    for (int i = 0; i < 64; i++) check(i_sscd_mem_model.mem[8'h10 + i], 8'h40 + i);
    check(i_sscd_mem_model.mem[PB_FIRST_KEY], RC_OK);
    check(i_sscd_mem_model.mem[PB_SECOND_KEY], 8'h00);
    check(n_res, n0 + 1);
    pblk(FIRST_KEY_VALUE, 8'h40, 8'h02);
    call(FN_READ);
    check(i_sscd_mem_model.mem[PB_FIRST_KEY], RC_PROT);
    check(i_sscd_mem_model.mem[PB_SECOND_KEY], 8'h00);
    check(n_clr, 2);
  endtask
  task automatic t_fops();
    ops.delete();
    // each call clears the keys on return, so the block is set up again
    pblk(FIRST_KEY_VALUE, 8'h40, 8'h01);
    call(FN_WRITE);
    pblk(FIRST_KEY_VALUE, 8'h40, 8'h01);
    call(FN_ERASE);
    pblk(FIRST_KEY_VALUE, 8'h40, 8'h01);
    call(FN_ERASE_ALL);
    exp = '{FOP_ROW_WRITE, FOP_ROW_ERASE, FOP_ERASE, FOP_PROG_ZERO, FOP_ERASE,
      FOP_PROT_ERASE, FOP_PROT_ZERO};
    check(ops.size(), 7);
    for (int i = 0; i < 7 && i < ops.size(); i++) check(ops[i], exp[i]);
    check(i_sscd_mem_model.mem[PB_FIRST_KEY], RC_OK);
  endtask
  task automatic t_data();
    int c0;
    sum = 8'h00;
    for (int i = 0; i < 64; i++) sum = sum + 8'h40 + i;
    pblk(FIRST_KEY_VALUE, 8'h40, 8'h01);
    c0 = n_clr;
    call(FN_CHECKSUM);
    check(i_sscd_mem_model.mem[PB_FIRST_KEY], sum);
    check(i_sscd_mem_model.mem[PB_SECOND_KEY], 8'h43);
    check(n_clr, c0);
    pblk(FIRST_KEY_VALUE, 8'h40, 8'h03);
    call(FN_TABLE);
    check(i_sscd_mem_model.mem[PB_FIRST_KEY], i_sscd_mem_model.aux[8'h83]);
    pblk(8'h00, 8'h40, 8'h01);
    call(FN_BOOT);
    check(cpu_halt, 1'b0);
    check(i_sscd_mem_model.mem[PB_FIRST_KEY], RC_SWRST);
  endtask
  task automatic t_halt();
    pblk(8'h00, 8'h40, 8'h01);
    call(FN_READ);
    check(cpu_halt, 1'b1);
    check(i_sscd_mem_model.mem[PB_FIRST_KEY], 8'h00);
    rst();
    check(cpu_halt, 1'b0);
    pblk(FIRST_KEY_VALUE, 8'h40, 8'h01);
    call(8'h04);
    check(cpu_halt, 1'b1);
    apb(0, REG_STATUS, 32'h0000_0000);
    check(rd[2], 1'b1);
    rst();
  endtask
  task automatic t_apb();
    cpu_exec <= 1;
    cpu_opcode <= 8'h7F;
    @(posedge pclk);
    cpu_exec <= 0;
    @(posedge pclk);
    check(cpu_hold, 1'b0);
    apb(1, REG_CAL_SUM, 32'h0000_BEEF);
    apb(0, REG_CAL_SUM, 32'h0000_0000);
    check(rd[15:0], 16'hBEEF);
    apb(1, REG_CAL_SUM, 32'h0000_0000);
    apb(0, 12'h010, 32'h0000_0000);
    check(er, 1'b1);
    apb(1, REG_QUEUE, 32'h0000_0006);
    check(cpu_hold, 1'b0);
  endtask
  task automatic t_queue();
    pin_a <= 1;
    pin_b <= 0;
    repeat (5) @(posedge pclk);
    pblk(FIRST_KEY_VALUE, 8'h40, 8'h03);
    n0 = n_res;
    apb(1, REG_QUEUE, 32'h0000_0006);
    for (int i = 0; i < 100; i++) begin
      apb(0, REG_STATUS, 32'h0000_0000);
      if (rd[1] === 1'b0) break;
    end
    check(rd[3], 1'b1);
    check(i_sscd_mem_model.mem[PB_FIRST_KEY], i_sscd_mem_model.aux[8'h83]);
    check(n_res, n0);
    pin_a <= 0;
  endtask
  initial begin
    {psel, penable, pwrite, cpu_exec, pin_a, pin_b} = '0;
    {paddr, pwdata, cpu_opcode, cpu_acc, cpu_sp} = '0;
    failures = 0;
    n_tests = 0;
    n_res = 0;
    n_clr = 0;
    presetn = 0;
    rst();
    check(cpu_halt, 1'b0);
    t_apb();
    t_read();
    t_fops();
    t_data();
    t_halt();
    t_queue();
    stop_test();
  end
  initial begin
    #300000;
    failures++;
    stop_test();
  end
endmodule // test_sscd_dispatcher
bind sscd_dispatcher sscd_dispatcher_props i_sscd_dispatcher_props (.pclk(pclk),
  .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .cpu_exec(cpu_exec), .cpu_opcode(cpu_opcode), .cpu_hold(cpu_hold), .cpu_halt(cpu_halt),
  .cpu_resume(cpu_resume), .acc_clear(acc_clear), .supervisory_rom_space(supervisory_rom_space),
  .flash_re(flash_re), .fop(fop), .fop_req(fop_req), .fop_done(fop_done));
